// File: core/tcba_pkg.sv
// Constants shared by the two-class bus arbiter and its selector
package tcba_pkg;
	localparam int          N_HI         = 5;
	localparam int          N_LO         = 3;
	localparam int          SYNC_STAGES  = 2;

	// State encodings: six-bit codes, three-bit upper and lower fields
	localparam logic [2:0]  ST_WAIT_UP   = 3'b111;
	localparam logic [5:0]  ST_W0        = 6'h3f;
	localparam logic [5:0]  ST_W1        = 6'h3e;
	localparam logic [5:0]  ST_W2        = 6'h3d;
	localparam logic [5:0]  ST_W3        = 6'h3c;
	localparam logic [5:0]  ST_W4        = 6'h3b;
	localparam logic [2:0]  ST_W_LOW_MIN = 3'h3;
	localparam logic [5:0]  ST_GA0       = 6'h06;
	localparam logic [5:0]  ST_GA1       = 6'h07;
	localparam logic [5:0]  ST_GA2       = 6'h0e;
	localparam logic [5:0]  ST_GA3       = 6'h0f;
	localparam logic [5:0]  ST_GA4       = 6'h16;
	localparam logic [2:0]  ST_GB0_UP    = 3'b101;
	localparam logic [2:0]  ST_GB1_UP    = 3'b110;
	localparam logic [2:0]  ST_GB2_UP    = 3'b100;
	localparam logic [5:0]  ST_RESET     = 6'h3f;

	// Grant vector, active low: [4:0] high class, [7:5] low class
	localparam logic [7:0]  GNT_NONE     = 8'hff;
	localparam int          GNT_LO_BASE  = 5;
endpackage

// File: core/tcba_sel_if.sv
// Request and choice signals between arbiter and priority selector
`timescale 1ns/1ps
interface tcba_sel_if;
	logic [4:0] hi_req;
	logic [2:0] lo_req;
	logic [2:0] start;
	logic       hi_any;
	logic [2:0] hi_idx;
	logic       lo_any;
	logic [1:0] lo_idx;

	modport sel (
		input  hi_req,
		input  lo_req,
		input  start,
		output hi_any,
		output hi_idx,
		output lo_any,
		output lo_idx
	);
	modport arb (
		output hi_req,
		output lo_req,
		output start,
		input  hi_any,
		input  hi_idx,
		input  lo_any,
		input  lo_idx
	);
endinterface

// File: core/tcba_sel.sv
// Rotating high-class and fixed low-class priority selector
`timescale 1ns/1ps
module tcba_sel (
	tcba_sel_if.sel s
);
	logic [3:0] cand;

	// Ring scan starting at the wait index, so that one is on top
	always_comb begin
		cand     = 4'h0;
		s.hi_any = 1'b0;
		s.hi_idx = 3'h0;
		for (int k = tcba_pkg::N_HI - 1; k >= 0; k--) begin
			cand = {1'b0, s.start} + 4'(k);
			if (cand >= 4'(tcba_pkg::N_HI)) begin
				cand = cand - 4'(tcba_pkg::N_HI);
			end
			if (s.hi_req[cand[2:0]]) begin
				s.hi_any = 1'b1;
				s.hi_idx = cand[2:0];
			end
		end
	end

	// Fixed order, index 0 wins; never rotates
	always_comb begin
		s.lo_any = |s.lo_req;
		if (s.lo_req[0]) begin
			s.lo_idx = 2'd0;
		end else if (s.lo_req[1]) begin
			s.lo_idx = 2'd1;
		end else begin
			s.lo_idx = 2'd2;
		end
	end
endmodule // tcba_sel

// File: core/tcba_arbiter.sv
// Two-class synchronous bus arbiter with one-clock guard band
`timescale 1ns/1ps

// How it works
// - Low class served only without high requests
// - Last granted high requester drops to lowest
// - Low class fixed order, index 0 first
// - Exactly one grant held while request held
// - One grantless wait clock after each release
// - Five high, three low, all active low
// - Wait states 3F to 3B evaluate requests
// - High 1 held in state 07 alone
// - Release of high N goes to wait N+1
// - Wait M puts high M on top
// - Low grant returns to its own wait state
// - Only low 2 pending enters 100xxx grant
// - Low grant keeps low bits as return address
// - Preset forces all state and grants high
// - Undefined conditions hold state and grants
// - Six state bits, eight grant bits, one edge
// - Grants fall entering grant, rise entering wait
// - Next values combinational, registered on clock
// - Control pin is preset or output enable
module tcba_arbiter #(
	parameter bit PIN_IS_PRESET = 1'b1
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic [4:0] req_hi_n,
	input  wire logic [2:0] req_lo_n,
	input  wire logic       preset_or_output_enable_pin,
	output logic      [7:0] grant_n,
	output logic            grant_oe,
	output logic      [5:0] arb_state
);
	logic [7:0] req_meta;
	logic [7:0] req_sync;
	logic       pin_meta;
	logic       pin_sync;
	logic       async_preset;
	logic [5:0] state;
	logic [5:0] next_state;
	logic [7:0] next_grant;
	logic [4:0] hi_req;
	logic [2:0] lo_req;
	logic       in_wait;
	logic [2:0] wait_idx;
	logic [2:0] succ_idx;
	logic [2:0] ga_idx;
	logic       in_ga;
	logic [1:0] gb_idx;
	logic       in_gb;

	tcba_sel_if sel_bus ();

	tcba_sel u_sel (
		.s (sel_bus.sel)
	);

	// Preset only when the shared pin is strapped that way
	assign async_preset = PIN_IS_PRESET & preset_or_output_enable_pin;

	// Requests are asynchronous to us; two flops kill metastability
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			req_meta <= tcba_pkg::GNT_NONE;
			req_sync <= tcba_pkg::GNT_NONE;
		end else begin
			req_meta <= {req_lo_n, req_hi_n};
			req_sync <= req_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			pin_meta <= preset_or_output_enable_pin;
			pin_sync <= pin_meta;
		end
	end

	// Active-high internal view of the low-asserted lines
	assign hi_req = ~req_sync[4:0];
	assign lo_req = ~req_sync[7:5];

	// Wait code low bits 111..011 map to index 0..4
	assign in_wait  = (state[5:3] == tcba_pkg::ST_WAIT_UP) &&
	                  (state[2:0] >= tcba_pkg::ST_W_LOW_MIN);
	assign wait_idx = ~state[2:0];

	assign sel_bus.hi_req = hi_req;
	assign sel_bus.lo_req = lo_req;
	assign sel_bus.start  = wait_idx;

	function automatic logic [5:0] ga_code(input logic [2:0] idx);
		unique case (idx)
			3'd0:    ga_code = tcba_pkg::ST_GA0;
			3'd1:    ga_code = tcba_pkg::ST_GA1;
			3'd2:    ga_code = tcba_pkg::ST_GA2;
			3'd3:    ga_code = tcba_pkg::ST_GA3;
			default: ga_code = tcba_pkg::ST_GA4;
		endcase
	endfunction

	function automatic logic [2:0] gb_up(input logic [1:0] idx);
		unique case (idx)
			2'd0:    gb_up = tcba_pkg::ST_GB0_UP;
			2'd1:    gb_up = tcba_pkg::ST_GB1_UP;
			default: gb_up = tcba_pkg::ST_GB2_UP;
		endcase
	endfunction

	// Decode which high grant, if any, the state holds
	always_comb begin
		in_ga  = 1'b1;
		ga_idx = 3'd0;
		unique case (state)
			tcba_pkg::ST_GA0: ga_idx = 3'd0;
			tcba_pkg::ST_GA1: ga_idx = 3'd1;
			tcba_pkg::ST_GA2: ga_idx = 3'd2;
			tcba_pkg::ST_GA3: ga_idx = 3'd3;
			tcba_pkg::ST_GA4: ga_idx = 3'd4;
			default:          in_ga  = 1'b0;
		endcase
	end

	always_comb begin
		in_gb  = 1'b1;
		gb_idx = 2'd0;
		unique case (state[5:3])
			tcba_pkg::ST_GB0_UP: gb_idx = 2'd0;
			tcba_pkg::ST_GB1_UP: gb_idx = 2'd1;
			tcba_pkg::ST_GB2_UP: gb_idx = 2'd2;
			default:             in_gb  = 1'b0;
		endcase
	end

	// Successor wait index, closing the ring after high 4
	assign succ_idx = (ga_idx == 3'(tcba_pkg::N_HI - 1)) ? 3'd0 :
	                  ga_idx + 3'd1;

	always_comb begin
		next_state = state;
		next_grant = grant_n;
		if (in_wait) begin
			if (sel_bus.hi_any) begin
				next_state = ga_code(sel_bus.hi_idx);
				next_grant = tcba_pkg::GNT_NONE;
				next_grant[sel_bus.hi_idx] = 1'b0;
			end else if (sel_bus.lo_any) begin
				// Low bits kept as the return address
				next_state = {gb_up(sel_bus.lo_idx), state[2:0]};
				next_grant = tcba_pkg::GNT_NONE;
				next_grant[tcba_pkg::GNT_LO_BASE + 32'(sel_bus.lo_idx)] =
					1'b0;
			end
		end else if (in_ga) begin
			if (!hi_req[ga_idx]) begin
				next_state = {tcba_pkg::ST_WAIT_UP, ~succ_idx};
				next_grant = tcba_pkg::GNT_NONE;
			end
		end else if (in_gb) begin
			if (!lo_req[gb_idx]) begin
				next_state = {tcba_pkg::ST_WAIT_UP, state[2:0]};
				next_grant = tcba_pkg::GNT_NONE;
			end
		end
	end

	// State and grants share one edge and one preset
	always_ff @(posedge sys_clk or posedge async_preset) begin
		if (async_preset) begin
			state <= tcba_pkg::ST_RESET;
		end else if (sys_rst) begin
			state <= tcba_pkg::ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk or posedge async_preset) begin
		if (async_preset) begin
			grant_n <= tcba_pkg::GNT_NONE;
		end else if (sys_rst) begin
			grant_n <= tcba_pkg::GNT_NONE;
		end else begin
			grant_n <= next_grant;
		end
	end

	assign arb_state = state;

	// In enable mode a high pin floats the grant drivers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			grant_oe <= 1'b0;
		end else begin
			grant_oe <= PIN_IS_PRESET ? 1'b1 : ~pin_sync;
		end
	end

	AST_ONE_GRANT: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		$countones(~grant_n) <= 1)
		else $error("more than one grant low");

	AST_HI_BLOCKS_LO: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && (|hi_req)) |=> (grant_n[7:5] == 3'b111))
		else $error("low grant while high request pending");

	AST_GUARD_BAND: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(grant_n != tcba_pkg::GNT_NONE) ##1 (grant_n == tcba_pkg::GNT_NONE)
		|-> in_wait)
		else $error("release did not land in a wait state");

	AST_HOLD_GA1: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(state == tcba_pkg::ST_GA1 && hi_req[1]) |=>
		(state == tcba_pkg::ST_GA1 && grant_n == 8'hfd))
		else $error("grant to high 1 not held");

	AST_RELEASE_GA1: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(state == tcba_pkg::ST_GA1 && !hi_req[1]) |=>
		(state == tcba_pkg::ST_W2 && grant_n == tcba_pkg::GNT_NONE))
		else $error("high 1 release did not reach wait 2");

	AST_RING_WRAP: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(state == tcba_pkg::ST_GA4 && !hi_req[4]) |=>
		(state == tcba_pkg::ST_W0))
		else $error("high 4 release did not wrap to wait 0");

	AST_LO_RETURN: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_gb && !lo_req[gb_idx]) |=>
		(state[5:3] == tcba_pkg::ST_WAIT_UP &&
		 state[2:0] == $past(state[2:0])))
		else $error("low grant did not return to its wait state");

	AST_LO2_ENTRY: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && hi_req == 5'h00 && lo_req == 3'b100) |=>
		(state[5:3] == tcba_pkg::ST_GB2_UP &&
		 state[2:0] == $past(state[2:0]) && grant_n == 8'h7f))
		else $error("low 2 grant entry wrong");

	AST_LO_FIXED: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && hi_req == 5'h00 && lo_req[0]) |=> (grant_n == 8'hdf))
		else $error("low 0 did not win");

	AST_RING_TOP: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && hi_req[wait_idx]) |=> !grant_n[$past(wait_idx)])
		else $error("wait index requester not on top");

	AST_UNDEF_HOLD: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(!in_wait && !in_ga && !in_gb) |=>
		($stable(state) && $stable(grant_n)))
		else $error("undefined state did not hold");

	AST_WAIT_NO_GRANT: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		in_wait |-> (grant_n == tcba_pkg::GNT_NONE))
		else $error("grant low in a wait state");

	AST_GRANT_IN_GRANT: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(grant_n != tcba_pkg::GNT_NONE) |-> (in_ga || in_gb))
		else $error("grant low outside a grant state");

	AST_GA_ONE_LINE: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		in_ga |-> (!grant_n[ga_idx] && $countones(~grant_n) == 1))
		else $error("high grant state drives wrong grant line");

	AST_GB_ONE_LINE: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		in_gb |-> (!grant_n[tcba_pkg::GNT_LO_BASE + 32'(gb_idx)] &&
		           $countones(~grant_n) == 1))
		else $error("low grant state drives wrong grant line");

	AST_HI_HOLD: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_ga && hi_req[ga_idx]) |=>
		($stable(state) && $stable(grant_n)))
		else $error("high grant dropped while request held");

	AST_LO_HOLD: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_gb && lo_req[gb_idx]) |=>
		($stable(state) && $stable(grant_n)))
		else $error("low grant dropped while request held");

	AST_HI_RELEASE: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_ga && !hi_req[ga_idx]) |=>
		(in_wait && grant_n == tcba_pkg::GNT_NONE &&
		 wait_idx == (($past(ga_idx) == 3'(tcba_pkg::N_HI - 1)) ? 3'd0 :
		              $past(ga_idx) + 3'd1)))
		else $error("high release did not reach the next wait state");

	AST_WAIT_LEAVES: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && ((|hi_req) || (|lo_req))) |=> !in_wait)
		else $error("pending request kept waiting past one clock");

	AST_IDLE_HOLDS: assert property (@(posedge sys_clk)
		disable iff (sys_rst || async_preset)
		(in_wait && hi_req == 5'h00 && lo_req == 3'h0) |=>
		($stable(state) && grant_n == tcba_pkg::GNT_NONE))
		else $error("idle wait state did not hold");
endmodule // tcba_arbiter

// File: verification/tcba_procs.sv
// Processor-side request drivers for the arbiter bench
`timescale 1ns/1ps
module tcba_procs (
	input  wire logic       sys_clk,
	input  wire logic [7:0] want,
	output logic      [4:0] req_hi_n,
	output logic      [2:0] req_lo_n
);
	// Registered on the system clock so setup is never marginal
	always_ff @(posedge sys_clk) begin
		{req_lo_n, req_hi_n} <= ~want;
	end
endmodule // tcba_procs

// File: verification/testbench.sv
// Self-checking bench for the two-class bus arbiter
`timescale 1ns/1ps
module testbench;
	logic       sys_clk     = 1'b0;
	logic       sys_rst     = 1'b1;
	logic       pin         = 1'b0;
	logic [7:0] want        = 8'h00;
	logic [4:0] req_hi_n;
	logic [2:0] req_lo_n;
	logic [7:0] grant_n;
	logic       grant_oe;
	logic [5:0] arb_state;
	logic       oe_pin      = 1'b0;
	logic [7:0] oe_grant_n;
	logic       oe_grant_oe;
	logic [5:0] oe_arb_state;
	int         err_count   = 0;
	int         check_count = 0;

	always #2 sys_clk = ~sys_clk;

	tcba_procs i_tcba_procs (.sys_clk(sys_clk), .want(want),
		.req_hi_n(req_hi_n), .req_lo_n(req_lo_n));

	tcba_arbiter i_tcba_arbiter (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_hi_n(req_hi_n), .req_lo_n(req_lo_n),
		.preset_or_output_enable_pin(pin), .grant_n(grant_n),
		.grant_oe(grant_oe), .arb_state(arb_state));

	// Same requests, shared pin strapped as output enable
	tcba_arbiter #(.PIN_IS_PRESET(1'b0)) i_tcba_arbiter_oe (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_hi_n(req_hi_n), .req_lo_n(req_lo_n),
		.preset_or_output_enable_pin(oe_pin), .grant_n(oe_grant_n),
		.grant_oe(oe_grant_oe), .arb_state(oe_arb_state));

	task automatic wrap_up;
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bit order of w: [4:0] high class, [7:5] low class, active high
	task automatic go(input logic [7:0] w, input logic [5:0] st,
			input logic [7:0] g);
		int n;
		@(negedge sys_clk);
		want = w;
		n = 0;
		while (arb_state !== st && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		check({2'h0, arb_state}, {2'h0, st});
		check(grant_n, g);
	endtask

	task automatic t_reset;
		repeat (2) @(negedge sys_clk);
		check({2'h0, arb_state}, 8'h3f);
		check(grant_n, 8'hff);
		check({7'h0, grant_oe}, 8'h01);
		check({7'h0, oe_grant_oe}, 8'h01);
		check({2'h0, oe_arb_state}, 8'h3f);
	endtask

	task automatic t_ring;
		go(8'h02, 6'h07, 8'hfd);
		go(8'h06, 6'h07, 8'hfd);
		repeat (6) @(negedge sys_clk);
		check({2'h0, arb_state}, 8'h07);
		check(grant_n, 8'hfd);
		go(8'h04, 6'h3d, 8'hff);
		go(8'h04, 6'h0e, 8'hfb);
		// Wait 3 puts high 4 ahead of 0 and 1
		go(8'h13, 6'h16, 8'hef);
	endtask

	task automatic t_guard;
		go(8'h03, 6'h3f, 8'hff);
		@(negedge sys_clk);
		check({2'h0, arb_state}, 8'h06);
		check(grant_n, 8'hfe);
		go(8'h00, 6'h3e, 8'hff);
	endtask

	task automatic t_low;
		go(8'he0, 6'h2e, 8'hdf);
		go(8'hc0, 6'h3e, 8'hff);
		go(8'hc0, 6'h36, 8'hbf);
		go(8'h80, 6'h3e, 8'hff);
		go(8'h80, 6'h26, 8'h7f);
		// Low 0 and high 3 appear together: high must win
		go(8'h28, 6'h0f, 8'hf7);
	endtask

	task automatic t_preset;
		@(negedge sys_clk);
		pin  = 1'b1;
		want = 8'h00;
		#1;
		check({2'h0, arb_state}, 8'h3f);
		check(grant_n, 8'hff);
		check({7'h0, grant_oe}, 8'h01);
		// Preset spares the syncs: hold it until old requests drain
		repeat (4) @(negedge sys_clk);
		check({2'h0, arb_state}, 8'h3f);
		check(grant_n, 8'hff);
		pin = 1'b0;
		go(8'h00, 6'h3f, 8'hff);
		repeat (4) @(negedge sys_clk);
		check({2'h0, arb_state}, 8'h3f);
		check(grant_n, 8'hff);
		// Enable-mode copy was never preset: high 3 release went to W4
		check({2'h0, oe_arb_state}, 8'h3b);
		check(oe_grant_n, 8'hff);
		go(8'h01, 6'h06, 8'hfe);
	endtask

	task automatic t_enable;
		check({2'h0, oe_arb_state}, 8'h06);
		@(negedge sys_clk);
		oe_pin = 1'b1;
		repeat (2) @(negedge sys_clk);
		check({7'h0, oe_grant_oe}, 8'h01);
		@(negedge sys_clk);
		check({7'h0, oe_grant_oe}, 8'h00);
		check({2'h0, oe_arb_state}, 8'h06);
		check(oe_grant_n, 8'hfe);
		check({7'h0, grant_oe}, 8'h01);
		oe_pin = 1'b0;
		repeat (3) @(negedge sys_clk);
		check({7'h0, oe_grant_oe}, 8'h01);
	endtask

	initial begin
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset;
		t_ring;
		t_guard;
		t_low;
		t_preset;
		t_enable;
		wrap_up;
	end

	// Whole run is about a hundred cycles
	initial begin
		#20000;
		err_count++;
		wrap_up;
	end
endmodule // testbench
